// ==== design/pot_nv_pkg.sv ====
// Constants and types for the two-wire potentiometer slave
package pot_nv_pkg;
    localparam int unsigned CLK_PERIOD_NS = 5;
    localparam int unsigned T_NV_WRITE_NS = 20000000;
    localparam int unsigned NV_WRITE_CYCLES = T_NV_WRITE_NS / CLK_PERIOD_NS;
    localparam int unsigned NV_CNT_W = 22;
    localparam int unsigned PWRUP_CYCLES = 16;
    localparam int unsigned PU_CNT_W = 8;
    localparam logic [3:0] ID_PREFIX = 4'hA;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [7:0] WIPER_RESET = 8'h80;
    localparam logic [7:0] PON_DEFAULT = 8'h80;
    localparam logic [7:0] GP_DEFAULT = 8'h00;
    localparam logic [7:0] ACR_NV_ACCESS = 8'h00;
    localparam logic [7:0] ACR_VOLATILE = 8'h80;
    localparam logic [7:0] ACR_RESET = 8'h00;
    localparam logic [7:0] ADDR_MAX = 8'h08;
    localparam logic [3:0] ADDR_FIRST = 4'h0;
    localparam logic [3:0] ADDR_LAST_WIPER = 4'h3;
    localparam logic [3:0] ADDR_LAST_NV = 4'h6;
    localparam logic [3:0] ADDR_ACR = 4'h8;

    typedef enum logic [7:0] {
        ST_POWERUP = 8'h01,
        ST_IDLE = 8'h02,
        ST_ID = 8'h04,
        ST_ADDR = 8'h08,
        ST_WDATA = 8'h10,
        ST_WDONE = 8'h20,
        ST_READ = 8'h40,
        ST_NVWR = 8'h80
    } slave_state_t;

    typedef struct packed {
        logic [7:0] tap3;
        logic [7:0] tap2;
        logic [7:0] tap1;
        logic [7:0] tap0;
    } wiper_bank_t;

    typedef struct packed {
        logic nv_busy;
        logic powering_up;
        logic volatile_access;
    } slave_status_t;
endpackage

// ==== design/pot_i2c_slave_nv_access.sv ====
// Two-wire slave with wiper, power-on store and access-control logic
`timescale 1ns/1ps
module pot_i2c_slave_nv_access #(
    parameter int unsigned NV_WRITE_CYCLES = pot_nv_pkg::NV_WRITE_CYCLES,
    parameter int unsigned PWRUP_CYCLES = pot_nv_pkg::PWRUP_CYCLES
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic scl_clk,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n,
    input wire logic bus_select_bit2,
    input wire logic bus_select_bit1,
    input wire logic bus_select_bit0,
    input wire logic write_protect_n,
    output pot_nv_pkg::wiper_bank_t wipers,
    output pot_nv_pkg::slave_status_t status
);
    import pot_nv_pkg::*;

    slave_state_t st_r, st_nxt;
    logic scl_m_r, scl_s_r, scl_d_r;
    logic sda_m_r, sda_s_r, sda_d_r;
    logic [2:0] sel_m_r, sel_s_r;
    logic wp_m_r, wp_s_r;
    logic [7:0] link_shift_r;
    logic [3:0] cnt_r, cnt_nxt;
    logic ackph_r, ackph_nxt;
    logic oe_n_r, oe_n_nxt;
    logic [7:0] tx_r, tx_nxt;
    logic [3:0] ptr_r, ptr_nxt;
    logic pend_r, pend_nxt;
    logic [7:0] nvd_r, nvd_nxt;
    logic [7:0] acr_r;
    logic [7:0] wip_r [0:3];
    logic [7:0] nv_mem_r [0:7];
    logic [NV_CNT_W-1:0] nv_cnt_r;
    logic [PU_CNT_W-1:0] pu_cnt_r;

    wire scl_rise = scl_s_r & ~scl_d_r;
    wire scl_fall = ~scl_s_r & scl_d_r;
    wire start_w = scl_s_r & scl_d_r & sda_d_r & ~sda_s_r;
    wire stop_w = scl_s_r & scl_d_r & ~sda_d_r & sda_s_r;
    wire on_bus = (st_r != ST_IDLE) & (st_r != ST_POWERUP) &
                  (st_r != ST_NVWR);
    wire byte_done = on_bus & scl_fall & ~ackph_r &
                     (cnt_r == BITS_PER_BYTE);
    wire ack_end = on_bus & scl_fall & ackph_r;
    // Link byte is stable from its eighth rise until the next rise
    wire [7:0] byte_w = link_shift_r;
    wire id_match = (byte_w[7:4] == ID_PREFIX) & (byte_w[3:1] == sel_s_r);
    wire addr_ok = (byte_w <= ADDR_MAX);
    wire commit_w = byte_done & (st_r == ST_WDATA) & wp_s_r;
    wire wiper_wr = commit_w & (ptr_r <= ADDR_LAST_WIPER);
    wire acr_wr = commit_w & (ptr_r == ADDR_ACR);
    wire nv_target = (ptr_r <= ADDR_LAST_NV) & (acr_r == ACR_NV_ACCESS);
    wire [3:0] ptr_inc = (ptr_r == ADDR_ACR) ? ADDR_FIRST : ptr_r + 4'h1;
    wire rd_volatile = (ptr_r <= ADDR_LAST_WIPER) & (acr_r == ACR_VOLATILE);
    wire [7:0] rd_w = (ptr_r == ADDR_ACR) ? acr_r :
                      rd_volatile ? wip_r[ptr_r[1:0]] : nv_mem_r[ptr_r[2:0]];
    wire nv_done = (st_r == ST_NVWR) & (nv_cnt_r == '0);
    wire pu_done = (st_r == ST_POWERUP) & (pu_cnt_r == '0);

    // shift in MSB first on the link clock
    always_ff @(posedge scl_clk) begin
        link_shift_r <= {link_shift_r[6:0], sda_i};
    end

    // Pin synchronisers; idle bus reads high
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            {scl_m_r, scl_s_r, scl_d_r} <= 3'h7;
            {sda_m_r, sda_s_r, sda_d_r} <= 3'h7;
            sel_m_r <= 3'h0;
            sel_s_r <= 3'h0;
            wp_m_r <= 1'h0;
            wp_s_r <= 1'h0;
        end else begin
            {scl_m_r, scl_s_r, scl_d_r} <= {scl_clk, scl_m_r, scl_s_r};
            {sda_m_r, sda_s_r, sda_d_r} <= {sda_i, sda_m_r, sda_s_r};
            sel_m_r <= {bus_select_bit2, bus_select_bit1, bus_select_bit0};
            sel_s_r <= sel_m_r;
            wp_m_r <= write_protect_n;
            wp_s_r <= wp_m_r;
        end
    end

    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        ackph_nxt = ackph_r;
        oe_n_nxt = oe_n_r;
        tx_nxt = tx_r;
        ptr_nxt = ptr_r;
        pend_nxt = pend_r;
        nvd_nxt = nvd_r;
        case (st_r)
            // START ignored; leave once stored values load
            ST_POWERUP: if (pu_done) st_nxt = ST_IDLE;
            // pins ignored and data released while busy
            ST_NVWR: begin
                oe_n_nxt = 1'h1;
                if (nv_done) st_nxt = ST_IDLE;
            end
            // standby waits only for a START
            ST_IDLE: oe_n_nxt = 1'h1;
            default: begin
                if (scl_rise & ~ackph_r)
                    cnt_nxt = cnt_r + 4'h1;
                // a whole extra pulse cancels; a STOP's own rise does not
                if (scl_fall & ~ackph_r & (st_r == ST_WDONE)) begin
                    st_nxt = ST_IDLE;
                    pend_nxt = 1'h0;
                end
                // a master nack ends the stream
                if (scl_rise & ackph_r & (st_r == ST_READ) & sda_s_r)
                    st_nxt = ST_IDLE;
                if (byte_done) begin
                    ackph_nxt = 1'h1;
                    cnt_nxt = 4'h0;
                    oe_n_nxt = 1'h1;
                    case (st_r)
                        ST_ID: if (id_match) begin
                            oe_n_nxt = 1'h0;
                            st_nxt = byte_w[0] ? ST_READ : ST_ADDR;
                        end else st_nxt = ST_IDLE;
                        ST_ADDR: if (addr_ok) begin
                            oe_n_nxt = 1'h0;
                            ptr_nxt = byte_w[3:0];
                            st_nxt = ST_WDATA;
                        end else st_nxt = ST_IDLE;
                        ST_WDATA: if (wp_s_r) begin
                            oe_n_nxt = 1'h0;
                            st_nxt = ST_WDONE;
                            pend_nxt = nv_target;
                            nvd_nxt = byte_w;
                        end else st_nxt = ST_IDLE;
                        // advance and wrap after location 8
                        ST_READ: ptr_nxt = ptr_inc;
                        default: st_nxt = ST_IDLE;
                    endcase
                end
                if (ack_end) begin
                    ackph_nxt = 1'h0;
                    oe_n_nxt = 1'h1;
                    // first bit of the next byte after the ack
                    if (st_r == ST_READ) begin
                        tx_nxt = rd_w;
                        oe_n_nxt = rd_w[7];
                    end
                end
                if (scl_fall & ~ackph_r & (st_r == ST_READ) &
                    (cnt_r != 4'h0) & (cnt_r != BITS_PER_BYTE)) begin
                    oe_n_nxt = tx_r[6];
                    tx_nxt = {tx_r[6:0], 1'h0};
                end
                // STOP ends the frame, launching a pending write
                if (stop_w) begin
                    st_nxt = (st_r == ST_WDONE) & pend_r ? ST_NVWR : ST_IDLE;
                    oe_n_nxt = 1'h1;
                    ackph_nxt = 1'h0;
                end
                if (start_w) begin
                    st_nxt = ST_ID;
                    cnt_nxt = 4'h0;
                    ackph_nxt = 1'h0;
                    oe_n_nxt = 1'h1;
                    pend_nxt = 1'h0;
                end
            end
        endcase
        // a START in standby opens a frame
        if ((st_r == ST_IDLE) & start_w) begin
            st_nxt = ST_ID;
            cnt_nxt = 4'h0;
            ackph_nxt = 1'h0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            st_r <= ST_POWERUP;
            cnt_r <= 4'h0;
            ackph_r <= 1'h0;
            oe_n_r <= 1'h1;
            tx_r <= 8'h00;
            ptr_r <= 4'h0;
            pend_r <= 1'h0;
            nvd_r <= 8'h00;
        end else begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            ackph_r <= ackph_nxt;
            oe_n_r <= oe_n_nxt;
            tx_r <= tx_nxt;
            ptr_r <= ptr_nxt;
            pend_r <= pend_nxt;
            nvd_r <= nvd_nxt;
        end
    end

    // busy time counts down from the parameter
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            nv_cnt_r <= '0;
            pu_cnt_r <= PU_CNT_W'(PWRUP_CYCLES - 1);
        end else begin
            if ((st_nxt == ST_NVWR) & (st_r != ST_NVWR))
                nv_cnt_r <= NV_CNT_W'(NV_WRITE_CYCLES - 1);
            else if (st_r == ST_NVWR)
                nv_cnt_r <= nv_cnt_r - NV_CNT_W'(1);
            if (st_r == ST_POWERUP)
                pu_cnt_r <= pu_cnt_r - PU_CNT_W'(1);
        end
    end

    // access-control byte is volatile and resets to zero
    always_ff @(posedge sys_clk) begin
        if (reset)
            acr_r <= ACR_RESET;
        else if (acr_wr)
            acr_r <= byte_w;
    end

    // wipers sit at mid-scale until the stored values load
    // wiper copy on the last data bit
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            for (int i = 0; i < 4; i++) wip_r[i] <= WIPER_RESET;
        end else if (pu_done) begin
            for (int i = 0; i < 4; i++) wip_r[i] <= nv_mem_r[i];
        end else if (wiper_wr) begin
            wip_r[ptr_r[1:0]] <= byte_w;
        end
    end

    // Stored bytes reset only to model factory contents in simulation
    // stored byte written when the busy time ends
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            for (int i = 0; i < 8; i++)
                nv_mem_r[i] <= (i < 4) ? PON_DEFAULT : GP_DEFAULT;
        end else if (nv_done) begin
            nv_mem_r[ptr_r[2:0]] <= nvd_r;
        end
    end

    // open-drain, low only when acknowledging or sending zero
    assign sda_o = 1'h0;
    assign sda_oe_n = oe_n_r;
    assign wipers = '{tap3: wip_r[3], tap2: wip_r[2],
                      tap1: wip_r[1], tap0: wip_r[0]};
    assign status = '{nv_busy: (st_r == ST_NVWR),
                      powering_up: (st_r == ST_POWERUP),
                      volatile_access: (acr_r == ACR_VOLATILE)};

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    sequence s_id_ok;
        byte_done && (st_r == ST_ID) && id_match;
    endsequence
    sequence s_id_bad;
        byte_done && (st_r == ST_ID) && !id_match;
    endsequence

    a_pwrup_released: assert property (
        (st_r == ST_POWERUP) |-> sda_oe_n)
        else $error("data pin driven during power-up");
    a_nvwr_silent: assert property (
        (st_r == ST_NVWR) |=> sda_oe_n)
        else $error("data pin driven during stored write");
    a_start_ignored: assert property (
        (st_r == ST_NVWR) && start_w && !nv_done |=> (st_r == ST_NVWR))
        else $error("start accepted while busy");
    a_id_ack: assert property (
        s_id_ok |=> !sda_oe_n && (st_r != ST_IDLE))
        else $error("valid identification not acknowledged");
    a_id_nack: assert property (
        s_id_bad |=> sda_oe_n && (st_r == ST_IDLE))
        else $error("mismatched identification acknowledged");
    a_wp_refuse: assert property (
        byte_done && (st_r == ST_WDATA) && !wp_s_r
        |=> sda_oe_n && (st_r == ST_IDLE) && $stable(acr_r))
        else $error("protected data byte taken");
    a_ptr_wrap: assert property (
        byte_done && (st_r == ST_READ) && (ptr_r == ADDR_ACR)
        |=> (ptr_r == ADDR_FIRST))
        else $error("read pointer did not wrap");
    a_nv_launch: assert property (
        stop_w && (st_r == ST_WDONE) && pend_r
        |=> (st_r == ST_NVWR) ##1 (nv_cnt_r == NV_CNT_W'(NV_WRITE_CYCLES - 2)))
        else $error("stop did not launch stored write");
    a_nv_finish: assert property (
        nv_done |=> (st_r == ST_IDLE) && (nv_mem_r[ptr_r[2:0]] == nvd_r))
        else $error("stored write did not complete");
    a_pwrup_load: assert property (
        pu_done |=> (wip_r[0] == nv_mem_r[0]) && (wip_r[3] == nv_mem_r[3]))
        else $error("wipers not loaded from store");
    a_wiper_copy: assert property (
        wiper_wr |=> (wip_r[ptr_r[1:0]] == $past(byte_w)))
        else $error("wiper not updated on last bit");
endmodule

// ==== dv/i2c_master_model.sv ====
// Two-wire bus master model that drives the serial clock
`timescale 1ns/1ps
module i2c_master_model (
    input wire logic sda,
    output logic scl_clk,
    output logic sda_low
);
    // Idle bus: clock stands high, data released to the pull-up
    initial begin
        scl_clk = 1'b1;
        sda_low = 1'b0;
    end
    // data changes only while the clock is low
    task automatic bit_out(input logic b);
        #40 sda_low = !b;
        #40 scl_clk = 1'b1;
        #80 scl_clk = 1'b0;
    endtask
    // master releases the line before each sampled bit
    task automatic bit_in(output logic b);
        #40 sda_low = 1'b0;
        #40 scl_clk = 1'b1;
        b = sda;
        #80 scl_clk = 1'b0;
    endtask
    // START, also a repeated START inside a frame
    task automatic start();
        if (!scl_clk) begin
            #40 sda_low = 1'b0;
            #40 scl_clk = 1'b1;
        end
        #40 sda_low = 1'b1;
        #40 scl_clk = 1'b0;
    endtask
    // STOP closes every frame, clock then stands high
    task automatic stop();
        #40 sda_low = 1'b1;
        #40 scl_clk = 1'b1;
        #40 sda_low = 1'b0;
        #80;
    endtask
    // eight bits MSB first, ack sampled on the ninth clock
    task automatic send(input logic [7:0] d, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) bit_out(d[i]);
        bit_in(b);
        ack = !b;
    endtask
    // ack asks for another byte, no ack before the STOP
    task automatic recv(input logic more, output logic [7:0] d);
        for (int i = 7; i >= 0; i--) bit_in(d[i]);
        bit_out(!more);
    endtask
endmodule

// ==== dv/tb_pot_i2c_slave_nv_access.sv ====
// Self-checking bench for the two-wire potentiometer slave
`timescale 1ns/1ps
module tb_pot_i2c_slave_nv_access;
    import pot_nv_pkg::*;
    // Short busy time keeps the run small; still longer than one frame
    localparam int unsigned NV_CYC = 2000;
    logic sys_clk, reset, sda, sda_o, sda_oe_n, scl_clk, sda_low, ack, b;
    logic write_protect_n;
    logic [2:0] sel;
    logic [7:0] acr, d, v, a;
    logic [7:0] vol [0:3];
    logic [7:0] nv [0:7];
    wiper_bank_t wipers;
    slave_status_t status;
    int miscompares, cmp_count, seed;

    // Open-drain wire with pull-up
    assign sda = (sda_low || (!sda_oe_n && !sda_o)) ? 1'b0 : 1'b1;

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    pot_i2c_slave_nv_access #(
        .NV_WRITE_CYCLES(NV_CYC),
        .PWRUP_CYCLES(4)
    ) u_dut (
        .sys_clk(sys_clk),
        .reset(reset),
        .scl_clk(scl_clk),
        .sda_i(sda),
        .sda_o(sda_o),
        .sda_oe_n(sda_oe_n),
        .bus_select_bit2(sel[2]),
        .bus_select_bit1(sel[1]),
        .bus_select_bit0(sel[0]),
        .write_protect_n(write_protect_n),
        .wipers(wipers),
        .status(status)
    );

    i2c_master_model u_master (
        .sda(sda),
        .scl_clk(scl_clk),
        .sda_low(sda_low)
    );

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic end_of_test();
        $display("miscompares=%0d cmp_count=%0d", miscompares, cmp_count);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        while (status.nv_busy !== 1'b0 && n < 3 * NV_CYC) begin
            @(posedge sys_clk);
            n++;
        end
        if (n >= 3 * NV_CYC) begin
            miscompares++;
            end_of_test();
        end
    endtask

    function automatic logic [7:0] exp_rd(input int p);
        if (p == 8) return acr;
        if (p < 4 && acr == ACR_VOLATILE) return vol[p];
        return nv[p];
    endfunction

    // Whole write frame, reference copies updated alongside
    task automatic wr(input logic [7:0] wa, input logic [7:0] wv);
        logic nvw;
        nvw = write_protect_n && wa <= 6 && acr == ACR_NV_ACCESS;
        u_master.start();
        u_master.send({ID_PREFIX, sel, 1'b0}, ack);
        chk(ack, 1);
        u_master.send(wa, ack);
        chk(ack, 1);
        u_master.send(wv, ack);
        chk(ack, write_protect_n);
        u_master.stop();
        if (write_protect_n && wa < 4) vol[wa] = wv;
        if (nvw) nv[wa] = wv;
        if (write_protect_n && wa == 8) acr = wv;
        repeat (20) @(posedge sys_clk);
        chk(status.nv_busy, nvw);
        if (nvw) begin
            u_master.start();
            u_master.send({ID_PREFIX, sel, 1'b0}, ack);
            chk(ack, 0);
            u_master.stop();
            wait_idle();
        end
        chk(wipers, {vol[3], vol[2], vol[1], vol[0]});
        chk(status.volatile_access, acr == ACR_VOLATILE);
    endtask

    // Pointer read of n bytes starting at ra
    task automatic rd(input logic [7:0] ra, input int n);
        int p;
        u_master.start();
        u_master.send({ID_PREFIX, sel, 1'b0}, ack);
        u_master.send(ra, ack);
        chk(ack, 1);
        u_master.start();
        u_master.send({ID_PREFIX, sel, 1'b1}, ack);
        chk(ack, 1);
        p = ra;
        for (int i = 0; i < n; i++) begin
            u_master.recv(i < n - 1, d);
            if (p != 7) chk(d, exp_rd(p));
            p = (p == 8) ? 0 : p + 1;
        end
        u_master.stop();
    endtask

    initial begin
        #400000;
        miscompares++;
        end_of_test();
    end

    initial begin
        seed = 43941;
        miscompares = 0;
        cmp_count = 0;
        reset = 1'b1;
        write_protect_n = 1'b1;
        sel = 3'($random(seed));
        acr = ACR_RESET;
        for (int i = 0; i < 8; i++) nv[i] = (i < 4) ? PON_DEFAULT : GP_DEFAULT;
        for (int i = 0; i < 4; i++) vol[i] = WIPER_RESET;
        repeat (16) @(posedge sys_clk);
        #1 reset = 1'b0;
        chk(sda_oe_n, 1);
        chk(wipers, {4{WIPER_RESET}});
        repeat (40) @(posedge sys_clk);
        chk(status.powering_up, 0);
        // Every wrong select pattern: no ack, later bytes ignored
        for (int k = 1; k < 8; k++) begin
            u_master.start();
            u_master.send({ID_PREFIX, sel ^ 3'(k), 1'(k)}, ack);
            chk(ack, 0);
            u_master.send(8'h00, ack);
            chk(ack, 0);
            u_master.stop();
        end
        wr(8'h08, ACR_VOLATILE);
        for (int k = 0; k < 4; k++) begin
            wr({6'h00, 2'($random(seed))}, 8'($random(seed)));
        end
        rd(8'h04, 11);
        wr(8'h08, ACR_NV_ACCESS);
        wr(8'h02, 8'($random(seed)));
        wr(8'h05, 8'($random(seed)));
        rd(8'h00, 9);
        @(posedge sys_clk);
        #1 write_protect_n = 1'b0;
        repeat (4) @(posedge sys_clk);
        wr(8'h01, 8'($random(seed)));
        @(posedge sys_clk);
        #1 write_protect_n = 1'b1;
        repeat (4) @(posedge sys_clk);
        // Address beyond the map is refused
        a = 8'h09 + 8'($unsigned($random(seed)) % 247);
        u_master.start();
        u_master.send({ID_PREFIX, sel, 1'b0}, ack);
        u_master.send(a, ack);
        chk(ack, 0);
        u_master.stop();
        // Extra clock after the data byte cancels the stored write
        v = 8'($random(seed));
        u_master.start();
        u_master.send({ID_PREFIX, sel, 1'b0}, ack);
        u_master.send(8'h03, ack);
        u_master.send(v, ack);
        u_master.bit_in(b);
        u_master.stop();
        vol[3] = v;
        repeat (20) @(posedge sys_clk);
        chk(status.nv_busy, 0);
        chk(wipers, {vol[3], vol[2], vol[1], vol[0]});
        rd(8'h03, 1);
        end_of_test();
    end
endmodule
